// ### verif/ivc_core_model.sv
// Core sequencer model: holds the system registers and issues accept and return
`timescale 1ns/1ps
module ivc_core_model
  import ivc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic cmdAccept,
  input wire logic cmdReti,
  input wire logic [3:0] cmdSrc,
  input wire logic cmdSet,
  input wire ivc_sysregs_t cmdRegs,
  input wire ivc_resp_t coreResp,
  output ivc_req_t coreReq,
  output ivc_sysregs_t sysRegsIn
);
  // ----------------------------------------------------------------
  // System register file
  // ----------------------------------------------------------------
  ivc_sysregs_t regs_q;

  // Requests pass straight through; the bench paces them one edge apart
  assign coreReq = '{cmdAccept, cmdSrc, cmdReti};
  // Fresh values must reach the block in the accept cycle itself
  assign sysRegsIn = cmdSet ? cmdRegs : regs_q;

  // A load ordered by the block wins over a bench update
  always_ff @(posedge clk_sys) begin
    if (coreResp.regsLoad) begin
      regs_q <= coreResp.regsOut;
    end else if (cmdSet) begin
      regs_q <= cmdRegs;
    end
  end
endmodule

// ### verif/tb.sv
// Testbench: drives core requests and AHB-Lite accesses, scores the answers
`timescale 1ns/1ps
module tb
  import ivc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and scoreboard
  // ----------------------------------------------------------------
  typedef struct packed {
    logic isVec;
    logic load;
    logic ovf;
    logic [11:0] vec;
    ivc_sysregs_t regs;
  } ivc_note_t;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic ceRst = 1'b0;
  logic cmdAccept = 1'b0;
  logic cmdReti = 1'b0;
  logic cmdSet = 1'b0;
  logic [3:0] cmdSrc = 4'h0;
  ivc_sysregs_t cmdRegs = '0;
  ivc_req_t coreReq;
  ivc_sysregs_t sysRegsIn;
  ivc_resp_t coreResp;
  logic ovfReset;
  logic irq;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  int failures = 0;
  int compares = 0;
  ivc_note_t notes[$];
  ivc_sysregs_t shadow[$];
  ivc_note_t seen;

  always #5 clk_sys = ~clk_sys;

  ivc_top u_ivc_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .ceRst(ceRst), .coreReq(coreReq),
    .sysRegsIn(sysRegsIn), .coreResp(coreResp), .ovfReset(ovfReset), .irq(irq), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  ivc_core_model u_ivc_core_model (.clk_sys(clk_sys), .cmdAccept(cmdAccept), .cmdReti(cmdReti),
    .cmdSrc(cmdSrc), .cmdSet(cmdSet), .cmdRegs(cmdRegs), .coreResp(coreResp),
    .coreReq(coreReq), .sysRegsIn(sysRegsIn));

  // ----------------------------------------------------------------
  // Compare, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One single word transfer; waits on the slave, never on a fixed count
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    check(32'(hresp), 32'h0, "bus response");
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(v, exp, "register read");
  endtask

  // ----------------------------------------------------------------
  // Core request tasks; each notes what the block must answer
  // ----------------------------------------------------------------
  task automatic accept(input logic [3:0] src, input logic ovf);
    ivc_sysregs_t r;
    ivc_note_t n;
    r = ivc_sysregs_t'($urandom);
    n = '0;
    n.isVec = 1'b1;
    n.load = 1'b1;
    n.ovf = ovf;
    n.vec = 12'h00c - 12'(src);
    n.regs.window = r.window;
    @(posedge clk_sys);
    cmdAccept <= 1'b1;
    cmdSrc <= src;
    cmdSet <= 1'b1;
    cmdRegs <= r;
    notes.push_back(n);
    shadow.push_back(r);
    // The model stack drops its oldest set just as the block must
    if (shadow.size() > IVC_STACK_DEPTH) shadow.pop_front();
    @(posedge clk_sys);
    cmdAccept <= 1'b0;
    cmdSet <= 1'b0;
  endtask

  task automatic do_return();
    ivc_note_t n;
    n = '0;
    n.regs = shadow.pop_back();
    n.load = 1'b1;
    @(posedge clk_sys);
    cmdReti <= 1'b1;
    notes.push_back(n);
    @(posedge clk_sys);
    cmdReti <= 1'b0;
  endtask

  // Return with nothing saved: no restore, reset request only while enabled
  task automatic empty_return(input logic ovf);
    ivc_note_t n;
    n = '0;
    n.ovf = ovf;
    @(posedge clk_sys);
    cmdReti <= 1'b1;
    if (ovf) notes.push_back(n);
    @(posedge clk_sys);
    cmdReti <= 1'b0;
  endtask

  // Watches the core side; every pulse must match the oldest note
  always @(posedge clk_sys) begin
    #1;
    if (!sys_rst && (coreResp.regsLoad === 1'b1 || coreResp.vecValid === 1'b1 ||
                     ovfReset === 1'b1)) begin
      if (notes.size() == 0) begin
        failures++;
        $display("BAD %0t unexpected core response", $time);
      end else begin
        seen = notes.pop_front();
        check(32'(coreResp.regsLoad), 32'(seen.load), "load pulse");
        check(32'(coreResp.vecValid), 32'(seen.isVec), "vector pulse");
        check(32'(ovfReset), 32'(seen.ovf), "overflow reset");
        if (seen.isVec) check(32'(coreResp.vecAddr), 32'(seen.vec), "vector");
        if (seen.load) check(32'(coreResp.regsOut), 32'(seen.regs), "register set");
      end
    end
  end

  // Hang guard, well beyond the two hundred or so cycles the tests need
  initial begin
    #200000;
    failures++;
    $display("BAD %0t timeout", $time);
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(77770));
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk(IVC_ADDR_NEST, 32'h5);
    rd_chk(IVC_ADDR_STATUS, 32'h0);
    rd_chk(IVC_ADDR_MASK, 32'h0);
    wr(IVC_ADDR_NEST, 32'hffff_ffff);
    rd_chk(IVC_ADDR_NEST, 32'h5);
    rd_chk(32'h0000_0040, 32'h0);
    // Every source once, with its context saved and brought back
    for (int s = 0; s < 12; s++) begin
      accept(4'(s), 1'b0);
      rd_chk(IVC_ADDR_VECTOR, 32'h0000_000c - 32'(s));
      do_return();
    end
    // Nest five deep: the fifth drops the oldest set and asks for reset
    for (int l = 1; l <= 5; l++) begin
      accept(4'($urandom_range(11)), l == 5);
      rd_chk(IVC_ADDR_NEST, (l < 5) ? 32'(5 - l) : 32'h1);
    end
    repeat (4) do_return();
    rd_chk(IVC_ADDR_NEST, 32'h5);
    // Interrupt line: masked, raised, then cleared by writing one
    check(32'(irq), 32'h0, "irq masked");
    wr(IVC_ADDR_STATUS, 32'hf);
    wr(IVC_ADDR_MASK, 32'h1);
    accept(IVC_SRC_TMR3, 1'b0);
    repeat (2) @(posedge clk_sys);
    check(32'(irq), 32'h1, "irq raised");
    rd_chk(IVC_ADDR_STATUS, 32'h1);
    wr(IVC_ADDR_STATUS, 32'h1);
    repeat (2) @(posedge clk_sys);
    check(32'(irq), 32'h0, "irq cleared");
    // Chip-enable reset puts the pointer back to empty
    @(posedge clk_sys);
    ceRst <= 1'b1;
    @(posedge clk_sys);
    ceRst <= 1'b0;
    shadow.delete();
    rd_chk(IVC_ADDR_NEST, 32'h5);
    // Sources 12 to 15 are not decoded: no answer and no push
    @(posedge clk_sys);
    cmdAccept <= 1'b1;
    cmdSrc <= 4'hc + 4'($urandom_range(3));
    @(posedge clk_sys);
    cmdAccept <= 1'b0;
    rd_chk(IVC_ADDR_NEST, 32'h5);
    // Return with an empty stack: underflow flagged, reset asked while enabled
    empty_return(1'b1);
    rd_chk(IVC_ADDR_STATUS, 32'ha);
    wr(IVC_ADDR_CTRL, 32'h0);
    wr(IVC_ADDR_CTRL, 32'h1);
    rd_chk(IVC_ADDR_CTRL, 32'h0);
    empty_return(1'b0);
    rd_chk(IVC_ADDR_NEST, 32'h5);
    repeat (4) @(posedge clk_sys);
    check(32'(notes.size()), 32'h0, "answers outstanding");
    complete_run();
  end
endmodule

// ### verilog/ivc_context_stack.sv
// Context save stack: four register sets, addressed by the nesting pointer
`timescale 1ns/1ps
module ivc_context_stack
  import ivc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [2:0] nestPtr,
  input wire logic push,
  input wire ivc_sysregs_t pushData,
  output ivc_sysregs_t topData
);

  // Entry k-1 holds the set seen at pointer value k; index 0 is the newest when full
  ivc_sysregs_t mem [IVC_STACK_DEPTH];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // No reset on purpose: contents survive chip-enable reset and clock stop
  always_ff @(posedge clk_sys) begin
    if (push) begin
      if (nestPtr == IVC_PTR_FULL) begin
        // Fifth level: shift down so the oldest set falls off the end
        for (int i = IVC_STACK_DEPTH - 1; i > 0; i--) begin
          mem[i] <= mem[i-1];
        end
        mem[0] <= pushData;
      end else if (nestPtr != IVC_PTR_BAD) begin
        mem[2'(nestPtr - 3'h2)] <= pushData;
      end
    end
  end

  // Set that the pointer currently names; garbage when the stack is empty
  always_comb begin
    topData = mem[2'(nestPtr - 3'h1)];
  end

endmodule

// ### verilog/ivc_pkg.sv
// Package: constants and carrier types of the interrupt vector and context stack block
package ivc_pkg;

  // ----------------------------------------------------------------
  // Nesting pointer codes and stack geometry
  // ----------------------------------------------------------------
  localparam logic [2:0] IVC_PTR_EMPTY = 3'h5;
  localparam logic [2:0] IVC_PTR_FULL = 3'h1;
  localparam logic [2:0] IVC_PTR_BAD = 3'h0;
  localparam int IVC_STACK_DEPTH = 4;

  // ----------------------------------------------------------------
  // Interrupt source codes, in priority order
  // ----------------------------------------------------------------
  localparam logic [3:0] IVC_SRC_CE = 4'h0;
  localparam logic [3:0] IVC_SRC_EXT0 = 4'h1;
  localparam logic [3:0] IVC_SRC_EXT4 = 4'h5;
  localparam logic [3:0] IVC_SRC_TMR0 = 4'h6;
  localparam logic [3:0] IVC_SRC_TMR3 = 4'h9;
  localparam logic [3:0] IVC_SRC_SIO2 = 4'ha;
  localparam logic [3:0] IVC_SRC_SIO3 = 4'hb;

  // ----------------------------------------------------------------
  // Program-memory vectors
  // ----------------------------------------------------------------
  localparam logic [11:0] IVC_VEC_CE = 12'h00c;
  localparam logic [11:0] IVC_VEC_EXT0 = 12'h00b;
  localparam logic [11:0] IVC_VEC_EXT4 = 12'h007;
  localparam logic [11:0] IVC_VEC_TMR0 = 12'h006;
  localparam logic [11:0] IVC_VEC_TMR3 = 12'h003;
  localparam logic [11:0] IVC_VEC_SIO2 = 12'h002;
  localparam logic [11:0] IVC_VEC_SIO3 = 12'h001;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [31:0] IVC_ADDR_STATUS = 32'h0000_0000;
  localparam logic [31:0] IVC_ADDR_MASK = 32'h0000_0004;
  localparam logic [31:0] IVC_ADDR_NEST = 32'h0000_0008;
  localparam logic [31:0] IVC_ADDR_CTRL = 32'h0000_000c;
  localparam logic [31:0] IVC_ADDR_VECTOR = 32'h0000_0010;
  localparam int IVC_STS_W = 4;
  localparam int IVC_ST_ACCEPT = 0;
  localparam int IVC_ST_RETURN_FROM_INTERRUPT_INSTR = 1;
  localparam int IVC_ST_OVF = 2;
  localparam int IVC_ST_UNF = 3;
  localparam int IVC_CTRL_OVFEN = 0;
  localparam logic IVC_OVFEN_RST = 1'b1;
  localparam logic [3:0] IVC_STS_RST = 4'h0;
  localparam logic [3:0] IVC_MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] window;
    logic [3:0] bank;
    logic [11:0] index;
    logic [7:0] gptr;
    logic [3:0] psw;
  } ivc_sysregs_t;

  typedef struct packed {
    logic accept;
    logic [3:0] src;
    logic return_from_interrupt_instr;
  } ivc_req_t;

  typedef struct packed {
    logic vecValid;
    logic [11:0] vecAddr;
    logic regsLoad;
    ivc_sysregs_t regsOut;
  } ivc_resp_t;

endpackage

// ### verilog/ivc_top.sv
// Top: interrupt vector output, context stack control, AHB-Lite registers
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module ivc_top
  import ivc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ceRst,
  input wire ivc_req_t coreReq,
  input wire ivc_sysregs_t sysRegsIn,
  output ivc_resp_t coreResp,
  output logic ovfReset,
  output logic irq,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] nestPtr;
    logic [IVC_STS_W-1:0] sts;
    logic [IVC_STS_W-1:0] msk;
    logic ovfEn;
    logic ovfEnLocked;
    logic [11:0] lastVec;
    ivc_resp_t resp;
    logic ovfRst;
    logic irq;
    logic wrPend;
    logic [31:0] wrAddr;
    logic [31:0] rdata;
    logic readyOut;
    logic resp1;
  } ivc_state_t;

  ivc_state_t st_q;
  ivc_state_t st_d;
  ivc_sysregs_t stackTop;
  logic [11:0] vecNow;
  logic srcLegal;
  logic doPush;
  logic doPop;
  logic [IVC_STS_W-1:0] events;

  ivc_vector_gen u_vec (
    .src(coreReq.src),
    .vector(vecNow),
    .legal(srcLegal)
  );

  ivc_context_stack u_stack (
    .clk_sys(clk_sys),
    .nestPtr(st_q.nestPtr),
    .push(doPush),
    .pushData(sysRegsIn),
    .topData(stackTop)
  );

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // CE reset outranks both; an accept of a decoded source outranks a same-cycle return
  always_comb begin
    doPush = !ceRst && coreReq.accept && srcLegal;
    doPop = !ceRst && !doPush && coreReq.return_from_interrupt_instr;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    events = '0;
    st_d.resp.vecValid = 1'b0;
    st_d.resp.regsLoad = 1'b0;
    st_d.ovfRst = 1'b0;

    // Pointer and core-side answers
    if (ceRst) begin
      st_d.nestPtr = IVC_PTR_EMPTY;
    end else if (doPush) begin
      st_d.resp.vecValid = 1'b1;
      st_d.resp.vecAddr = vecNow;
      st_d.lastVec = vecNow;
      st_d.resp.regsLoad = 1'b1;
      st_d.resp.regsOut = '0;
      st_d.resp.regsOut.window = sysRegsIn.window;
      events[IVC_ST_ACCEPT] = 1'b1;
      if (st_q.nestPtr == IVC_PTR_FULL) begin
        // Pointer stays at four levels; the stack drops its oldest set
        events[IVC_ST_OVF] = 1'b1;
        st_d.ovfRst = st_q.ovfEn;
      end else begin
        st_d.nestPtr = st_q.nestPtr - 3'h1;
      end
    end else if (doPop) begin
      events[IVC_ST_RETURN_FROM_INTERRUPT_INSTR] = 1'b1;
      if (st_q.nestPtr == IVC_PTR_EMPTY) begin
        // Nothing saved: no restore, flag underflow instead
        events[IVC_ST_UNF] = 1'b1;
        st_d.ovfRst = st_q.ovfEn;
      end else begin
        st_d.resp.regsLoad = 1'b1;
        st_d.resp.regsOut = stackTop;
        st_d.nestPtr = st_q.nestPtr + 3'h1;
      end
    end

    // Bus write, data phase; the nesting pointer has no write path
    if (st_q.wrPend) begin
      if (st_q.wrAddr == IVC_ADDR_STATUS) begin
        st_d.sts = st_q.sts & ~hwdata[IVC_STS_W-1:0];
      end else if (st_q.wrAddr == IVC_ADDR_MASK) begin
        st_d.msk = hwdata[IVC_STS_W-1:0];
      end else if (st_q.wrAddr == IVC_ADDR_CTRL && !st_q.ovfEnLocked) begin
        // Write-once so a runaway program cannot disable the safety reset
        st_d.ovfEn = hwdata[IVC_CTRL_OVFEN];
        st_d.ovfEnLocked = 1'b1;
      end
    end
    // Set after clear so an event in the clearing cycle is kept
    st_d.sts = st_d.sts | events;
    st_d.irq = |(st_d.sts & st_d.msk);

    // Address phase capture; read data prepared from next state
    st_d.wrPend = hsel && hready && htrans[1] && hwrite;
    st_d.wrAddr = haddr;
    st_d.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr)
        IVC_ADDR_STATUS: st_d.rdata = {28'h000_0000, st_d.sts};
        IVC_ADDR_MASK: st_d.rdata = {28'h000_0000, st_d.msk};
        IVC_ADDR_NEST: st_d.rdata = {29'h0000_0000, st_d.nestPtr};
        IVC_ADDR_CTRL: st_d.rdata = {31'h0000_0000, st_d.ovfEn};
        IVC_ADDR_VECTOR: st_d.rdata = {20'h0_0000, st_d.lastVec};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    st_d.readyOut = 1'b1;
    st_d.resp1 = 1'b0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.nestPtr <= IVC_PTR_EMPTY;
      st_q.sts <= IVC_STS_RST;
      st_q.msk <= IVC_MASK_RST;
      st_q.ovfEn <= IVC_OVFEN_RST;
      st_q.readyOut <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  always_comb begin
    coreResp = st_q.resp;
    ovfReset = st_q.ovfRst;
    irq = st_q.irq;
    hreadyout = st_q.readyOut;
    hrdata = st_q.rdata;
    hresp = st_q.resp1;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  chk_pin_vector: assert property (
    doPush && coreReq.src <= IVC_SRC_EXT4
    |=> coreResp.vecValid && coreResp.vecAddr == 12'h00c - {8'h00, $past(coreReq.src)})
    else $error("pin source vector wrong");

  chk_int_vector: assert property (
    doPush && coreReq.src >= IVC_SRC_TMR0
    |=> coreResp.vecValid && coreResp.vecAddr == 12'h00c - {8'h00, $past(coreReq.src)})
    else $error("internal source vector wrong");

  chk_push_saved: assert property (
    doPush |=> stackTop == $past(sysRegsIn))
    else $error("pushed context not on stack top");

  chk_push_clear: assert property (
    doPush |=> coreResp.regsLoad && coreResp.regsOut.bank == 4'h0
    && coreResp.regsOut.index == 12'h000 && coreResp.regsOut.gptr == 8'h00
    && coreResp.regsOut.psw == 4'h0 && coreResp.regsOut.window == $past(sysRegsIn.window))
    else $error("registers not cleared after push");

  chk_ptr_range: assert property (
    st_q.nestPtr >= IVC_PTR_FULL && st_q.nestPtr <= IVC_PTR_EMPTY)
    else $error("nesting pointer out of range");

  chk_return_from_interrupt_instr_restore: assert property (
    doPop && st_q.nestPtr != IVC_PTR_EMPTY
    |=> coreResp.regsLoad && coreResp.regsOut == $past(stackTop))
    else $error("return did not restore newest set");

  chk_ptr_ro: assert property (
    st_q.wrPend && st_q.wrAddr == IVC_ADDR_NEST && !doPush && !doPop && !ceRst
    |=> $stable(st_q.nestPtr))
    else $error("pointer changed by a write");

  chk_ce_reset: assert property (
    ceRst |=> st_q.nestPtr == IVC_PTR_EMPTY && !coreResp.regsLoad && !coreResp.vecValid)
    else $error("CE reset did not empty pointer");

  chk_overflow_keep: assert property (
    doPush && st_q.nestPtr == IVC_PTR_FULL
    |=> st_q.nestPtr == 3'h1 && stackTop == $past(sysRegsIn) && st_q.sts[IVC_ST_OVF])
    else $error("fifth level mishandled");

  chk_ovf_reset: assert property (
    doPush && st_q.nestPtr == IVC_PTR_FULL && st_q.ovfEn
    |=> ovfReset ##1 (!ovfReset || $past(doPush || doPop)))
    else $error("overflow reset missing");

  chk_ptr_step: assert property (
    (doPush && st_q.nestPtr != IVC_PTR_FULL |=> st_q.nestPtr == $past(st_q.nestPtr) - 3'h1)
    and (doPop && st_q.nestPtr != IVC_PTR_EMPTY
    |=> st_q.nestPtr == $past(st_q.nestPtr) + 3'h1))
    else $error("pointer step wrong");

  // ----------------------------------------------------------------
  // Checks on the pointer, the bus and refused requests
  // ----------------------------------------------------------------
  // Some of these hold by construction today; they guard later edits
  // of the decode, where a slip would go unnoticed by the bench

  chk_window_kept: assert property (
    doPush |=> coreResp.regsOut.window == stackTop.window)
    else $error("window not kept across push");

  chk_empty_return: assert property (
    doPop && st_q.nestPtr == IVC_PTR_EMPTY
    |=> !coreResp.regsLoad && st_q.nestPtr == IVC_PTR_EMPTY && st_q.sts[IVC_ST_UNF])
    else $error("return at empty stack mishandled");

  chk_ptr_hold: assert property (
    !doPush && !doPop && !ceRst |=> $stable(st_q.nestPtr))
    else $error("pointer moved without a request");

  chk_ovf_quiet: assert property (
    doPush && st_q.nestPtr != IVC_PTR_FULL |=> !ovfReset)
    else $error("reset requested below level five");

  chk_nest_read: assert property (
    hsel && hready && htrans[1] && !hwrite && haddr == IVC_ADDR_NEST
    |=> hrdata == {29'h0000_0000, st_q.nestPtr})
    else $error("nesting pointer read wrong");

  chk_ovf_once: assert property (
    st_q.wrPend && st_q.wrAddr == IVC_ADDR_CTRL && st_q.ovfEnLocked
    |=> $stable(st_q.ovfEn))
    else $error("overflow reset enable written twice");

  chk_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("bus answer not ready and okay");

  chk_src_ignored: assert property (
    coreReq.accept && !srcLegal && !coreReq.return_from_interrupt_instr && !ceRst
    |=> !coreResp.vecValid && !coreResp.regsLoad)
    else $error("illegal source answered");

  // Main scenarios the bench must reach
  cov_four_deep: cover property (doPush && st_q.nestPtr == 3'h2);
  cov_overflow: cover property (doPush && st_q.nestPtr == IVC_PTR_FULL);
  cov_restore: cover property (doPop && st_q.nestPtr == 3'h4 ##1 st_q.nestPtr == IVC_PTR_EMPTY);
  cov_irq: cover property ($rose(irq));
  cov_empty_return: cover property (doPop && st_q.nestPtr == IVC_PTR_EMPTY);

endmodule

// ### verilog/ivc_vector_gen.sv
// Vector generator: maps an accepted source code to its program-memory vector
`timescale 1ns/1ps
module ivc_vector_gen
  import ivc_pkg::*;
(
  input wire logic [3:0] src,
  output logic [11:0] vector,
  output logic legal
);

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  // Pins count down from the chip-enable vector, timers from timer 0
  always_comb begin
    legal = 1'b1;
    vector = 12'h000;
    if (src <= IVC_SRC_EXT4) begin
      vector = IVC_VEC_CE - {8'h00, src - IVC_SRC_CE};
    end else if (src <= IVC_SRC_TMR3) begin
      vector = IVC_VEC_TMR0 - {8'h00, src - IVC_SRC_TMR0};
    end else if (src == IVC_SRC_SIO2) begin
      vector = IVC_VEC_SIO2;
    end else if (src == IVC_SRC_SIO3) begin
      vector = IVC_VEC_SIO3;
    end else begin
      legal = 1'b0;
    end
  end

endmodule
